// ---- rtl/rcw_pkg.sv ----
// shared constants for the configuration word and reference select block
package rcw_pkg;
   localparam logic [7:0]  RCW_ADDR_CFG      = 8'h0A;
   localparam logic [7:0]  RCW_ADDR_NV_REF   = 8'h0F;
   localparam logic [7:0]  RCW_ADDR_VLIM     = 8'h10;
   localparam logic [7:0]  RCW_ADDR_RAM_REF  = 8'h31;
   localparam logic [15:0] RCW_CFG_RESET     = 16'h1F34;
   localparam logic [15:0] RCW_NV_REF_RESET  = 16'h4000;
   localparam logic [15:0] RCW_VLIM_RESET    = 16'h1200;
   localparam logic [15:0] RCW_USED_MASK     = 16'h5FF6;
   localparam int          RCW_B_OFFSET      = 2;
   localparam int          RCW_B_JUMPER      = 4;
   localparam int          RCW_B_APO_INV     = 5;
   localparam int          RCW_B_FORCE_3PH   = 6;
   localparam int          RCW_B_RAM_CTRL    = 7;
   localparam int          RCW_B_VOLTAGE_SETPOINT_KNOB_TRIM   = 8;
   localparam int          RCW_B_STABILITY_KNOB_TRIM   = 9;
   localparam int          RCW_B_HZ_TRIM     = 10;
   localparam int          RCW_B_AMP_TRIM    = 11;
   localparam int          RCW_B_EXT_IN      = 12;
   localparam int          RCW_B_60HZ        = 14;
   localparam int          RCW_B_PERIODIC    = 1;

   // reference source, gray coded
   typedef enum logic [1:0] {
      RCW_SRC_ANA_FREE = 2'b00,
      RCW_SRC_ANA_SAT  = 2'b01,
      RCW_SRC_RAM      = 2'b11,
      RCW_SRC_NV       = 2'b10
   } rcw_src_t;
endpackage

// ---- rtl/rcw_word_reg.sv ----
// one 16-bit host-writable storage word with reset value
`timescale 1ns/10ps
module rcw_word_reg
   import rcw_pkg::*;
#(
   parameter logic [15:0] RESET_VAL = 16'h0000
)(
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_we,
   input  wire logic [15:0] i_wdata,
   output logic      [15:0] o_q
);
   typedef struct packed {
      logic [15:0] q;
   } rcw_wr_t;

   rcw_wr_t st;
   rcw_wr_t next_st;

   always_comb begin
      next_st = st;
      if (i_we) begin
         next_st.q = i_wdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st.q <= RESET_VAL;
      end else begin
         st <= next_st;
      end
   end

   assign o_q = st.q;
endmodule

// ---- rtl/rcw_cfg_ref_sel.sv ----
// configuration word decode and output voltage reference selection
//
// Operation
// RULE1: each configuration bit set enables its function, clear disables it
// RULE2: host computes a whole word as the sum of enabled bit weights
// RULE3: word resets to bits 2,4,5,8-12 set, value 7988
// RULE4: bit 2 enables offset compensation, only with single-phase sensing
// RULE5: bit 4 enables sampling of the 50/60 Hz jumper
// RULE6: with jumper disabled bit 14 selects 60 Hz, else 50 Hz
// RULE7: bit 12 enables analogue input; clear selects a digital reference
// RULE8: analogue enabled with bit 7 set saturates at the input limit
// RULE9: saturating and analogue link lost drives the variation-limit maximum
// RULE10: analogue off, bit 7 clear uses the stored nonvolatile reference
// RULE11: volatile location loads from and tracks nonvolatile reference
// RULE12: volatile writes ignored while the nonvolatile source is selected
// RULE13: analogue off, bit 7 set uses the software-written volatile location
// RULE14: bits 0,3,13,15 stored and read back but decode nothing
// RULE15: bit 5 inverts alarm contact, bit 6 forces three-phase sensing
// RULE16: word sits at parameter address 10, host readable and writable
`timescale 1ns/10ps
module rcw_cfg_ref_sel
   import rcw_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   input  wire logic [7:0]  i_addr,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_nv_we,
   input  wire logic [15:0] i_nv_wdata,
   input  wire logic        i_jumper_60hz,
   input  wire logic        i_three_phase_seen,
   input  wire logic        i_ext_link_ok,
   input  wire logic        i_ext_at_limit,
   input  wire logic [15:0] i_ext_value,
   input  wire logic        i_alarm_active,
   output logic      [15:0] o_rdata,
   output logic             o_rvalid,
   output logic      [15:0] o_cfg_word,
   output logic      [15:0] o_voltage_ref,
   output logic      [1:0]  o_ref_source,
   output logic             o_ref_saturated,
   output logic             o_rated_60hz,
   output logic             o_offset_comp_en,
   output logic             o_three_phase,
   output logic             o_alarm_output_contact,
   output logic             o_periodic_var_en,
   output logic             o_voltage_setpoint_knob_en,
   output logic             o_stability_knob_en,
   output logic             o_freq_knob_en,
   output logic             o_overexcitation_knob_en
);
   typedef struct packed {
      logic [15:0] ram_ref;
      logic [15:0] rdata;
      logic        rvalid;
      logic [15:0] vref;
      logic [1:0]  src;
      logic        sat;
      logic        hz60;
      logic        ofs;
      logic        ph3;
      logic        alarm_output_contact;
   } rcw_st_t;

   rcw_st_t     st;
   rcw_st_t     next_st;
   logic [15:0] cfg;
   logic [15:0] nv_ref;
   logic [15:0] vlim;
   logic        cfg_we;
   logic        nvref_we;
   logic [15:0] nvref_wd;

   // host write at address 10, or nonvolatile restore path
   assign cfg_we   = i_wr && (i_addr == RCW_ADDR_CFG); // see RULE16
   assign nvref_we = i_nv_we || (i_wr && (i_addr == RCW_ADDR_NV_REF));
   assign nvref_wd = i_nv_we ? i_nv_wdata : i_wdata;

   rcw_word_reg #(
      .RESET_VAL (RCW_CFG_RESET) // see RULE3
   ) u_cfg (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_we       (cfg_we),
      .i_wdata    (i_wdata),     // see RULE14
      .o_q        (cfg)
   );

   rcw_word_reg #(
      .RESET_VAL (RCW_NV_REF_RESET)
   ) u_nvref (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_we       (nvref_we),
      .i_wdata    (nvref_wd),
      .o_q        (nv_ref)
   );

   rcw_word_reg #(
      .RESET_VAL (RCW_VLIM_RESET)
   ) u_vlim (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_we       (i_wr && (i_addr == RCW_ADDR_VLIM)),
      .i_wdata    (i_wdata),
      .o_q        (vlim)
   );

   always_comb begin
      logic     ext_en;
      logic     ram_ctl;
      rcw_src_t src;
      ext_en  = 1'b0;
      ram_ctl = 1'b0;
      src     = RCW_SRC_NV;
      next_st = st;

      // only used bits steer behaviour; others just stored
      ext_en  = cfg[RCW_B_EXT_IN];  // see RULE1 see RULE7
      ram_ctl = cfg[RCW_B_RAM_CTRL];

      case ({ext_en, ram_ctl})
         2'b10: begin
            src = RCW_SRC_ANA_FREE;
         end
         2'b11: begin
            src = RCW_SRC_ANA_SAT;  // see RULE8
         end
         2'b01: begin
            src = RCW_SRC_RAM;      // see RULE13
         end
         2'b00: begin
            src = RCW_SRC_NV;       // see RULE10
         end
         default: begin
            src = RCW_SRC_NV;
         end
      endcase
      next_st.src = src;

      // volatile location tracks nv reference unless bit 7 set
      if (!ram_ctl) begin
         next_st.ram_ref = nv_ref;  // see RULE11 see RULE12
      end else if (i_wr && (i_addr == RCW_ADDR_RAM_REF)) begin
         next_st.ram_ref = i_wdata; // see RULE13
      end

      next_st.sat = 1'b0;
      case (src)
         RCW_SRC_ANA_FREE: begin
            next_st.vref = i_ext_value;
         end
         RCW_SRC_ANA_SAT: begin
            // lost link must not collapse the voltage: go to max
            if (!i_ext_link_ok) begin
               next_st.vref = vlim;  // see RULE9
               next_st.sat  = 1'b1;
            end else if (i_ext_at_limit) begin
               next_st.vref = vlim;  // see RULE8
               next_st.sat  = 1'b1;
            end else begin
               next_st.vref = i_ext_value;
            end
         end
         RCW_SRC_RAM: begin
            next_st.vref = st.ram_ref;
         end
         RCW_SRC_NV: begin
            next_st.vref = nv_ref;
         end
         default: begin
            next_st.vref = nv_ref;
         end
      endcase

      // jumper only sampled when bit 4 set
      next_st.hz60 = cfg[RCW_B_JUMPER] ? i_jumper_60hz // see RULE5
                                        : cfg[RCW_B_60HZ]; // see RULE6
      next_st.ph3  = cfg[RCW_B_FORCE_3PH] | i_three_phase_seen; // see RULE15
      next_st.ofs  = cfg[RCW_B_OFFSET] & ~next_st.ph3;          // see RULE4
      next_st.alarm_output_contact  = i_alarm_active ^ cfg[RCW_B_APO_INV];       // see RULE15

      next_st.rvalid = i_rd;
      case (i_addr)
         RCW_ADDR_CFG: begin
            next_st.rdata = cfg;      // see RULE16
         end
         RCW_ADDR_NV_REF: begin
            next_st.rdata = nv_ref;
         end
         RCW_ADDR_VLIM: begin
            next_st.rdata = vlim;
         end
         RCW_ADDR_RAM_REF: begin
            next_st.rdata = st.ram_ref;
         end
         default: begin
            next_st.rdata = 16'h0000;
         end
      endcase
      if (!i_rd) begin
         next_st.rdata = st.rdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st.ram_ref <= RCW_NV_REF_RESET; // see RULE11
         st.rdata   <= 16'h0000;
         st.rvalid  <= 1'b0;
         st.vref    <= RCW_NV_REF_RESET;
         st.src     <= RCW_SRC_ANA_FREE;
         st.sat     <= 1'b0;
         st.hz60    <= 1'b0;
         st.ofs     <= 1'b0;
         st.ph3     <= 1'b0;
         st.alarm_output_contact     <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata                    = st.rdata;
   assign o_rvalid                   = st.rvalid;
   assign o_cfg_word                 = cfg;
   assign o_voltage_ref              = st.vref;
   assign o_ref_source               = st.src;
   assign o_ref_saturated            = st.sat;
   assign o_rated_60hz               = st.hz60;
   assign o_offset_comp_en           = st.ofs;
   assign o_three_phase              = st.ph3;
   assign o_alarm_output_contact     = st.alarm_output_contact;
   assign o_periodic_var_en          = cfg[RCW_B_PERIODIC];
   assign o_voltage_setpoint_knob_en = cfg[RCW_B_VOLTAGE_SETPOINT_KNOB_TRIM];
   assign o_stability_knob_en        = cfg[RCW_B_STABILITY_KNOB_TRIM];
   assign o_freq_knob_en             = cfg[RCW_B_HZ_TRIM];
   assign o_overexcitation_knob_en   = cfg[RCW_B_AMP_TRIM];
endmodule

// ---- sim/rcw_cfg_ref_sel_monitor.sv ----
// assertions on the configuration word and reference select ports
`timescale 1ns/10ps
module rcw_cfg_ref_sel_monitor
   import rcw_pkg::*;
(
   input wire logic        i_core_clk,
   input wire logic        i_nrst,
   input wire logic [7:0]  i_addr,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] i_wdata,
   input wire logic        i_jumper_60hz,
   input wire logic        i_three_phase_seen,
   input wire logic        i_alarm_active,
   input wire logic        i_ext_link_ok,
   input wire logic        o_rvalid,
   input wire logic [15:0] o_cfg_word,
   input wire logic [15:0] o_voltage_ref,
   input wire logic [1:0]  o_ref_source,
   input wire logic        o_ref_saturated,
   input wire logic        o_rated_60hz,
   input wire logic        o_three_phase,
   input wire logic        o_alarm_output_contact,
   input wire logic        o_voltage_setpoint_knob_en
);
   logic [15:0] lim_model;
   logic [15:0] cfg_model;

   // port-side copies of limit and config word, built from host writes
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lim_model <= RCW_VLIM_RESET;
         cfg_model <= RCW_CFG_RESET;
      end else if (i_wr) begin
         if (i_addr == RCW_ADDR_VLIM) begin
            lim_model <= i_wdata;
         end
         if (i_addr == RCW_ADDR_CFG) begin
            cfg_model <= i_wdata;
         end
      end
   end

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   rd_answer_a: assert property (i_rd |=> o_rvalid)
      else $error("read strobe got no answer");
   cfg_store_a: assert property ((i_wr && i_addr == RCW_ADDR_CFG)
      |=> o_cfg_word == $past(i_wdata)) else $error("cfg word not stored");
   src_nv_a: assert property (!o_cfg_word[12] && !o_cfg_word[7]
      |=> o_ref_source == RCW_SRC_NV) else $error("nv source not chosen");
   src_ram_a: assert property (!o_cfg_word[12] && o_cfg_word[7]
      |=> o_ref_source == RCW_SRC_RAM) else $error("ram source not chosen");
   src_ana_a: assert property (o_cfg_word[12]
      |=> o_ref_source == {1'b0, $past(o_cfg_word[7])})
      else $error("analogue source wrong");
   sat_limit_a: assert property (o_ref_saturated |->
      o_voltage_ref == $past(lim_model))
      else $error("saturation value wrong");
   link_lost_a: assert property (o_cfg_word[12] && o_cfg_word[7]
      && !i_ext_link_ok |=> o_ref_saturated)
      else $error("lost link not saturated");
   cfg_model_a: assert property (o_cfg_word == cfg_model)
      else $error("cfg word differs from written value");
   // first edge after reset still shows reset levels, not decoded ones
   rated_freq_a: assert property ($past(i_nrst) |->
      o_rated_60hz == $past(o_cfg_word[4] ? i_jumper_60hz : o_cfg_word[14]))
      else $error("rated frequency wrong");
   alarm_inv_a: assert property ($past(i_nrst) |->
      o_alarm_output_contact == $past(i_alarm_active ^ o_cfg_word[5]))
      else $error("alarm polarity");
   three_ph_a: assert property ($past(i_nrst) |->
      o_three_phase == $past(o_cfg_word[6] | i_three_phase_seen))
      else $error("sensing mode");
   knob_bit_a: assert property (o_voltage_setpoint_knob_en
      == cfg_model[8]) else $error("knob enable wrong");
   cover property (o_ref_saturated);
   cover property (o_ref_source == RCW_SRC_RAM);
   cover property (o_ref_source == RCW_SRC_NV);
endmodule
bind rcw_cfg_ref_sel rcw_cfg_ref_sel_monitor u_mon (.*);

// ---- sim/tb.sv ----
// self-checking bench for configuration word and reference select
`timescale 1ns/10ps
module tb;
   import rcw_pkg::*;
   logic [15:0] i_wdata, i_nv_wdata, i_ext_value, o_rdata, o_cfg_word;
   logic [15:0] o_voltage_ref, c;
   logic [7:0]  i_addr;
   logic [1:0]  o_ref_source;
   logic i_core_clk, i_nrst, i_wr, i_rd, i_nv_we, i_jumper_60hz;
   logic i_three_phase_seen, i_ext_link_ok, i_ext_at_limit, i_alarm_active;
   logic o_rvalid, o_ref_saturated, o_rated_60hz, o_offset_comp_en;
   logic o_three_phase, o_alarm_output_contact, o_periodic_var_en;
   logic o_voltage_setpoint_knob_en, o_stability_knob_en, o_freq_knob_en;
   logic o_overexcitation_knob_en;
   int   num_errors, comparisons;
   logic [15:0] tbl [4] = '{16'h4164, 16'h0806, 16'h4030, 16'h0114};
   rcw_cfg_ref_sel dut (.*);
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chb(string n, logic e, logic g);
      chk(n, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic src(logic [1:0] e);
      chk("ref source", {14'h0000, e}, {14'h0000, o_ref_source});
   endtask
   // one write strobe, returns on the falling edge after it was taken
   task automatic wr(logic [7:0] a, logic [15:0] d);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_core_clk);
      i_wr = 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [15:0] e, string n);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_core_clk);
      i_rd = 1'b0;
      chk(n, e, o_rdata);
      chb("rvalid", 1'b1, o_rvalid);
   endtask
   // decoded outputs lag the cfg register by one more stage
   task automatic settle;
      repeat (2) @(negedge i_core_clk);
   endtask
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      {i_wr, i_rd, i_nv_we, i_jumper_60hz, i_nrst} = '0;
      {i_three_phase_seen, i_ext_at_limit, i_alarm_active} = '0;
      i_ext_link_ok = 1'b1;
      i_addr = '0;
      {i_wdata, i_nv_wdata} = '0;
      i_ext_value = 16'h0777;
      repeat (4) @(negedge i_core_clk);
      i_nrst = 1'b1;
      rd(RCW_ADDR_CFG, 16'h1F34, "cfg reset");
      src(2'b00);
      chk("vref", 16'h0777, o_voltage_ref);
      chb("stability_knob", 1'b1, o_stability_knob_en);
      chb("hz knob", 1'b1, o_freq_knob_en);
      chb("amp knob", 1'b1, o_overexcitation_knob_en);
      wr(RCW_ADDR_CFG, 16'hA009);
      rd(RCW_ADDR_CFG, 16'hA009, "cfg spare bits");
      settle;
      src(2'b10);
      chk("vref", 16'h4000, o_voltage_ref);
      wr(RCW_ADDR_RAM_REF, 16'h1234);
      rd(RCW_ADDR_RAM_REF, 16'h4000, "ram ref");
      i_nv_we = 1'b1;
      i_nv_wdata = 16'h2222;
      @(negedge i_core_clk);
      i_nv_we = 1'b0;
      settle;
      rd(RCW_ADDR_RAM_REF, 16'h2222, "ram ref");
      wr(RCW_ADDR_CFG, 16'h0080);
      settle;
      src(2'b11);
      wr(RCW_ADDR_RAM_REF, 16'h3456);
      settle;
      chk("vref", 16'h3456, o_voltage_ref);
      i_ext_at_limit = 1'b1;
      wr(RCW_ADDR_CFG, 16'h1000 + 16'h0080);
      settle;
      src(2'b01);
      chb("sat", 1'b1, o_ref_saturated);
      {i_ext_at_limit, i_ext_link_ok} = 2'b00;
      settle;
      chk("vref", 16'h1200, o_voltage_ref);
      chb("sat", 1'b1, o_ref_saturated);
      {i_ext_at_limit, i_ext_link_ok} = 2'b11;
      wr(RCW_ADDR_CFG, 16'h1000);
      settle;
      chb("sat", 1'b0, o_ref_saturated);
      src(2'b00);
      chk("vref", 16'h0777, o_voltage_ref);
      for (int i = 0; i < 4; i++) begin
         c = tbl[i];
         {i_alarm_active, i_jumper_60hz} = 2'(i);
         i_three_phase_seen = (i == 3);
         wr(RCW_ADDR_CFG, c);
         settle;
         chb("60hz", c[4] ? i_jumper_60hz : c[14], o_rated_60hz);
         chb("contact", c[5] ^ i_alarm_active,
             o_alarm_output_contact);
         chb("3ph", c[6] | (i == 3), o_three_phase);
         chb("offset", c[2] & ~(c[6] | (i == 3)),
             o_offset_comp_en);
         chb("knob", c[8], o_voltage_setpoint_knob_en);
         chb("periodic", c[1], o_periodic_var_en);
         chb("amp knob", c[11], o_overexcitation_knob_en);
      end
      rd(8'h20, 16'h0000, "unmapped");
      wrap_up;
   end
   // the sequence needs under 200 cycles
   initial begin
      #(3000 * 100);
      num_errors++;
      wrap_up;
   end
endmodule
